// [hw/spias_pkg.sv]
// constants for the serial port interrupt, status and error block
package spias_pkg;
  // register byte offsets
  localparam logic [7:0] SPIAS_OFF_CTRL = 8'h00;
  localparam logic [7:0] SPIAS_OFF_FLAGS = 8'h04;
  localparam logic [7:0] SPIAS_OFF_TXHOLD = 8'h08;
  localparam logic [7:0] SPIAS_OFF_RXHOLD = 8'h0c;
  localparam logic [7:0] SPIAS_OFF_BAUD = 8'h10;
  // serial_ctrl_reg fields
  localparam int SPIAS_C_TXE_IE = 0;
  localparam int SPIAS_C_RX_IE = 1;
  localparam int SPIAS_C_TXD_IE = 2;
  localparam int SPIAS_C_TE = 3;
  localparam int SPIAS_C_RE = 4;
  localparam int SPIAS_C_SYNC = 5;
  localparam int SPIAS_C_EXTCLK = 6;
  localparam int SPIAS_C_PAREN = 7;
  // serial_flags_reg fields
  localparam int SPIAS_F_TXE = 0;
  localparam int SPIAS_F_RXF = 1;
  localparam int SPIAS_F_OVR = 2;
  localparam int SPIAS_F_FRM = 3;
  localparam int SPIAS_F_PAR = 4;
  localparam int SPIAS_F_TXD = 5;
  // reset values
  localparam logic [7:0] SPIAS_CTRL_RST = 8'h00;
  localparam logic [7:0] SPIAS_BAUD_RST = 8'h00;
  // oversampling: last base clock index of a bit, sample point index
  localparam logic [3:0] SPIAS_OVS_LAST = 4'hf;
  localparam logic [3:0] SPIAS_OVS_SMP = 4'h7;
  localparam logic [2:0] SPIAS_LAST_BIT = 3'h7;
  // late-disable windows in half clocks; cycles round down
  localparam int SPIAS_WIN_EXT_HALF = 7;
  localparam int SPIAS_WIN_INT_HALF = 3;
  localparam logic [1:0] SPIAS_WIN_EXT_CYC = 2'((SPIAS_WIN_EXT_HALF / 2 < 1) ? 1 : SPIAS_WIN_EXT_HALF / 2);
  localparam logic [1:0] SPIAS_WIN_INT_CYC = 2'((SPIAS_WIN_INT_HALF / 2 < 1) ? 1 : SPIAS_WIN_INT_HALF / 2);
  // priority codes, highest first
  localparam logic [1:0] SPIAS_PRI_FAULT = 2'h0;
  localparam logic [1:0] SPIAS_PRI_RXF = 2'h1;
  localparam logic [1:0] SPIAS_PRI_TXE = 2'h2;
  localparam logic [1:0] SPIAS_PRI_TXD = 2'h3;
  localparam logic [1:0] SPIAS_RESP_OK = 2'h0;
  localparam logic [1:0] SPIAS_RESP_ERR = 2'h2;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} spias_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} spias_rx_st_t;
endpackage

// [hw/spias_top.sv]
// serial port with interrupt, status flag and receive error handling
`timescale 1ns/10ps
`default_nettype none
module spias_top
  import spias_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd_in,
  output logic txd_out,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  input wire logic dma_tx_wr,
  input wire logic [7:0] dma_tx_data,
  input wire logic dma_rx_rd,
  output logic [7:0] dma_rx_data,
  output logic rx_fault_irq,
  output logic rx_full_irq,
  output logic tx_empty_irq,
  output logic tx_done_irq,
  output logic irq_any,
  output logic [1:0] irq_top
);
  logic [7:0] ctrl_r, baud_r, baud_cnt_r, tx_hold_r, tx_shift_r, rx_shift_r;
  logic tx_empty_flag, rx_full_flag, overrun_flag, frame_fault_flag;
  logic parity_error_flag, tx_done_flag;
  logic aw_v_r, w_v_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic rxd_s1, rxd_s2, sck_s1, sck_s2, sck_s3;
  spias_tx_st_t tx_st_r;
  spias_rx_st_t rx_st_r;
  logic [3:0] tx_cnt_r, rx_cnt_r;
  logic [2:0] tx_idx_r, rx_idx_r;
  logic tx_real_r, seen_rise_r, rx_par_r, copy_pend_r;
  logic [1:0] copy_cnt_r;

  wire tx_empty_irq_en = ctrl_r[SPIAS_C_TXE_IE];
  wire rx_irq_en = ctrl_r[SPIAS_C_RX_IE];
  wire tx_done_irq_en = ctrl_r[SPIAS_C_TXD_IE];
  wire transmit_enable = ctrl_r[SPIAS_C_TE];
  wire rcv_enable = ctrl_r[SPIAS_C_RE];
  wire sync_mode = ctrl_r[SPIAS_C_SYNC];
  wire ext_clk = ctrl_r[SPIAS_C_EXTCLK];
  wire par_en = ctrl_r[SPIAS_C_PAREN];
  wire err_any = overrun_flag | frame_fault_flag | parity_error_flag;

  // bus write stage: address and data taken in either order
  wire wr_fire = aw_v_r && w_v_r && !s_axi_bvalid;
  wire wr_lane0 = wr_fire && w_strb_r[0];
  wire wr_ctrl = wr_lane0 && (aw_addr_r == ADDR_W'(SPIAS_OFF_CTRL));
  wire wr_flags = wr_lane0 && (aw_addr_r == ADDR_W'(SPIAS_OFF_FLAGS));
  wire wr_txh = wr_lane0 && (aw_addr_r == ADDR_W'(SPIAS_OFF_TXHOLD));
  wire wr_baud = wr_lane0 && (aw_addr_r == ADDR_W'(SPIAS_OFF_BAUD));
  logic wr_mapped;
  always_comb
  begin
    if (aw_addr_r == ADDR_W'(SPIAS_OFF_CTRL)) wr_mapped = 1'b1;
    else if (aw_addr_r == ADDR_W'(SPIAS_OFF_FLAGS)) wr_mapped = 1'b1;
    else if (aw_addr_r == ADDR_W'(SPIAS_OFF_TXHOLD)) wr_mapped = 1'b1;
    else if (aw_addr_r == ADDR_W'(SPIAS_OFF_RXHOLD)) wr_mapped = 1'b1;
    else if (aw_addr_r == ADDR_W'(SPIAS_OFF_BAUD)) wr_mapped = 1'b1;
    else wr_mapped = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_v_r <= 1'b0;
      w_v_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SPIAS_RESP_OK;
    end
    else if (ce)
    begin
      if (s_axi_awready && s_axi_awvalid)
      begin
        aw_v_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid)
      begin
        w_v_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? SPIAS_RESP_OK : SPIAS_RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_v_r <= 1'b0;
        w_v_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read stage: answer one cycle after the address is taken
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb
  begin
    rd_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    if (s_axi_araddr == ADDR_W'(SPIAS_OFF_CTRL)) rd_mux[7:0] = ctrl_r;
    else if (s_axi_araddr == ADDR_W'(SPIAS_OFF_FLAGS))
      rd_mux[5:0] = {tx_done_flag, parity_error_flag, frame_fault_flag, overrun_flag,
                     rx_full_flag, tx_empty_flag};
    else if (s_axi_araddr == ADDR_W'(SPIAS_OFF_TXHOLD)) rd_mux[7:0] = tx_hold_r;
    else if (s_axi_araddr == ADDR_W'(SPIAS_OFF_RXHOLD)) rd_mux[7:0] = dma_rx_data;
    else if (s_axi_araddr == ADDR_W'(SPIAS_OFF_BAUD)) rd_mux[7:0] = baud_r;
    else rd_ok = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SPIAS_RESP_OK;
    end
    else if (ce)
    begin
      if (s_axi_arready && s_axi_arvalid)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? SPIAS_RESP_OK : SPIAS_RESP_ERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // control, baud and transmit hold registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= SPIAS_CTRL_RST;
      baud_r <= SPIAS_BAUD_RST;
      tx_hold_r <= 8'h00;
    end
    else if (ce)
    begin
      if (wr_ctrl) ctrl_r <= w_data_r[7:0];
      if (wr_baud) baud_r <= w_data_r[7:0];
      // accepted whatever the empty flag says
      if (dma_tx_wr) tx_hold_r <= dma_tx_data;
      else if (wr_txh) tx_hold_r <= w_data_r[7:0];
    end
  end

  // pin synchronisers and base clock at 16x bit rate
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {rxd_s1, rxd_s2, sck_s1, sck_s2, sck_s3} <= 5'h1f;
      baud_cnt_r <= 8'h00;
    end
    else if (ce)
    begin
      rxd_s1 <= rxd_in;
      rxd_s2 <= rxd_s1;
      sck_s1 <= sck_in;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      baud_cnt_r <= (baud_cnt_r == 8'h00) ? baud_r : baud_cnt_r - 8'h01;
    end
  end
  wire tick = (baud_cnt_r == 8'h00);
  wire ext_rise = sck_s2 && !sck_s3;
  wire ext_fall = !sck_s2 && sck_s3;
  wire sync_ext = sync_mode && ext_clk;
  wire sync_int = sync_mode && !ext_clk;

  // transmitter
  wire bit_end = sync_ext ? (ext_fall && seen_rise_r) : (tick && tx_cnt_r == SPIAS_OVS_LAST);
  wire tx_frame_end = (tx_st_r != TX_IDLE) && bit_end &&
                      ((tx_st_r == TX_STOP) || (sync_mode && tx_st_r == TX_DATA &&
                       tx_idx_r == SPIAS_LAST_BIT));
  // receive errors hold off sync transmission
  wire tx_can = transmit_enable && !tx_empty_flag && !(sync_mode && err_any);
  // chain the next byte at frame end if one waits
  wire tx_load = tx_can && ((tx_st_r == TX_IDLE) || tx_frame_end);
  wire rx_only_go = sync_int && tx_st_r == TX_IDLE && rcv_enable && !transmit_enable &&
                    !rx_full_flag && !err_any;
  wire int_rise = sync_int && tx_st_r == TX_DATA && tick && tx_cnt_r == SPIAS_OVS_SMP;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_st_r <= TX_IDLE;
      tx_cnt_r <= 4'h0;
      tx_idx_r <= 3'h0;
      tx_shift_r <= 8'h00;
      tx_real_r <= 1'b0;
      seen_rise_r <= 1'b0;
      txd_out <= 1'b1;
      sck_out <= 1'b1;
      sck_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      // internal sync clock: low first half of each bit, high second half
      sck_out <= !(sync_int && tx_st_r == TX_DATA && !tx_cnt_r[3]);
      sck_oe_n <= !(sync_int && (transmit_enable || rcv_enable));
      if (ext_rise) seen_rise_r <= 1'b1;
      if (bit_end || tx_st_r == TX_IDLE) seen_rise_r <= 1'b0;
      if (tick) tx_cnt_r <= tx_cnt_r + 4'h1;
      // disabling the transmitter drops a transmit frame at once; a receive-only clock frame runs on
      if (!transmit_enable && !rx_only_go && !(tx_st_r != TX_IDLE && !tx_real_r))
      begin
        tx_st_r <= TX_IDLE;
        tx_real_r <= 1'b0;
        if (!sync_mode) txd_out <= 1'b1;
      end
      else if (tx_load)
      begin
        // shift register loaded here, empty flag set alongside
        tx_shift_r <= tx_hold_r;
        tx_real_r <= 1'b1;
        tx_cnt_r <= 4'h0;
        tx_idx_r <= 3'h0;
        tx_st_r <= sync_mode ? TX_DATA : TX_START;
        txd_out <= sync_mode ? tx_hold_r[0] : 1'b0;
      end
      else if (rx_only_go)
      begin
        tx_real_r <= 1'b0;
        tx_cnt_r <= 4'h0;
        tx_idx_r <= 3'h0;
        tx_st_r <= TX_DATA;
      end
      else if (bit_end)
      begin
        case (tx_st_r)
          TX_START:
          begin
            tx_st_r <= TX_DATA;
            txd_out <= tx_shift_r[0];
          end
          TX_DATA:
          begin
            tx_idx_r <= tx_idx_r + 3'h1;
            if (tx_idx_r != SPIAS_LAST_BIT)
            begin
              tx_shift_r <= {1'b0, tx_shift_r[7:1]};
              if (tx_real_r) txd_out <= tx_shift_r[1];
            end
            else if (sync_mode)
              // line keeps the final bit level after a sync frame
              tx_st_r <= TX_IDLE;
            else
            begin
              tx_st_r <= par_en ? TX_PAR : TX_STOP;
              txd_out <= par_en ? ^tx_hold_par(tx_shift_r) : 1'b1;
            end
          end
          TX_PAR:
          begin
            tx_st_r <= TX_STOP;
            txd_out <= 1'b1;
          end
          TX_STOP: tx_st_r <= TX_IDLE;
          default: tx_st_r <= TX_IDLE;
        endcase
      end
    end
  end

  // parity over the byte that just went out; shift keeps only bit 7 at the end
  logic [7:0] tx_par_src_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn) tx_par_src_r <= 8'h00;
    else if (ce && tx_load) tx_par_src_r <= tx_hold_r;
  end
  function automatic logic [7:0] tx_hold_par(input logic [7:0] unused_shift);
    tx_hold_par = tx_par_src_r;
  endfunction

  // receiver
  wire sync_rise = sync_ext ? ext_rise : int_rise;
  wire rx_smp = sync_mode ? sync_rise : (tick && rx_cnt_r == SPIAS_OVS_SMP);
  wire rx_sync_last = sync_mode && rx_st_r == RX_DATA && rx_idx_r == SPIAS_LAST_BIT;
  wire rx_done = rx_smp && (rx_st_r == RX_STOP || rx_sync_last);
  wire [7:0] rx_byte = rx_sync_last ? {rxd_s2, rx_shift_r[7:1]} : rx_shift_r;
  wire rx_perr = !sync_mode && par_en && (rx_par_r != ^rx_shift_r);
  wire rx_ferr = !sync_mode && !rxd_s2;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_st_r <= RX_IDLE;
      rx_cnt_r <= 4'h0;
      rx_idx_r <= 3'h0;
      rx_shift_r <= 8'h00;
      rx_par_r <= 1'b0;
    end
    else if (ce)
    begin
      // base clock count from start, sample at its eighth pulse
      if (tick) rx_cnt_r <= rx_cnt_r + 4'h1;
      if (!rcv_enable) rx_st_r <= RX_IDLE;
      else
      begin
        case (rx_st_r)
          RX_IDLE:
            // a low line restarts a frame, so a break refaults
            if (!sync_mode && !rxd_s2)
            begin
              rx_st_r <= RX_START;
              rx_cnt_r <= 4'h0;
            end
            else if (sync_mode && !err_any && sync_rise)
            begin
              rx_shift_r <= {rxd_s2, rx_shift_r[7:1]};
              rx_idx_r <= 3'h1;
              rx_st_r <= RX_DATA;
            end
          RX_START:
            if (rx_smp)
            begin
              rx_st_r <= rxd_s2 ? RX_IDLE : RX_DATA;
              rx_idx_r <= 3'h0;
            end
          RX_DATA:
            if (rx_smp)
            begin
              rx_shift_r <= {rxd_s2, rx_shift_r[7:1]};
              rx_idx_r <= rx_idx_r + 3'h1;
              if (rx_idx_r == SPIAS_LAST_BIT)
                rx_st_r <= sync_mode ? RX_IDLE : (par_en ? RX_PAR : RX_STOP);
            end
          RX_PAR:
            if (rx_smp)
            begin
              rx_par_r <= rxd_s2;
              rx_st_r <= RX_STOP;
            end
          RX_STOP: if (rx_smp) rx_st_r <= RX_IDLE;
          default: rx_st_r <= RX_IDLE;
        endcase
      end
    end
  end

  // receive hold and the delayed copy of sync mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dma_rx_data <= 8'h00;
      copy_pend_r <= 1'b0;
      copy_cnt_r <= 2'h0;
    end
    else if (ce)
    begin
      if (rx_done && !rx_full_flag && (!sync_mode))
        // good or faulty bytes without overrun reach the hold
        dma_rx_data <= rx_byte;
      else if (rx_done && !rx_full_flag)
      begin
        copy_pend_r <= 1'b1;
        copy_cnt_r <= ext_clk ? SPIAS_WIN_EXT_CYC : SPIAS_WIN_INT_CYC;
      end
      // late disable leaves the hold untouched
      else if (copy_pend_r && !rcv_enable) copy_pend_r <= 1'b0;
      else if (copy_pend_r && copy_cnt_r == 2'h1)
      begin
        copy_pend_r <= 1'b0;
        dma_rx_data <= rx_shift_r;
      end
      else if (copy_pend_r) copy_cnt_r <= copy_cnt_r - 2'h1;
    end
  end

  // status flags; a hardware set always beats a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_empty_flag <= 1'b1;
      tx_done_flag <= 1'b1;
      {rx_full_flag, overrun_flag, frame_fault_flag, parity_error_flag} <= 4'h0;
    end
    else if (ce)
    begin
      // load or disable sets, unit write clears
      if (!transmit_enable || tx_load) tx_empty_flag <= 1'b1;
      else if (dma_tx_wr || (wr_flags && !w_data_r[SPIAS_F_TXE])) tx_empty_flag <= 1'b0;
      // nothing waiting at frame end marks transmission done
      if (!transmit_enable || (tx_frame_end && tx_real_r && !tx_can)) tx_done_flag <= 1'b1;
      else if (tx_load || (wr_flags && !w_data_r[SPIAS_F_TXD])) tx_done_flag <= 1'b0;
      // clean byte sets full, unit read clears
      if (rx_done && !rx_full_flag && !rx_perr && !rx_ferr) rx_full_flag <= 1'b1;
      else if (dma_rx_rd || (wr_flags && !w_data_r[SPIAS_F_RXF])) rx_full_flag <= 1'b0;
      if (rx_done && rx_full_flag) overrun_flag <= 1'b1;
      else if (wr_flags && !w_data_r[SPIAS_F_OVR]) overrun_flag <= 1'b0;
      // framing fault sets again while the break persists
      if (rx_done && rx_ferr) frame_fault_flag <= 1'b1;
      else if (wr_flags && !w_data_r[SPIAS_F_FRM]) frame_fault_flag <= 1'b0;
      if (rx_done && rx_perr) parity_error_flag <= 1'b1;
      else if (wr_flags && !w_data_r[SPIAS_F_PAR]) parity_error_flag <= 1'b0;
    end
  end

  // request lines and priority code
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {rx_fault_irq, rx_full_irq, tx_empty_irq, tx_done_irq, irq_any} <= 5'h00;
      irq_top <= SPIAS_PRI_FAULT;
    end
    else if (ce)
    begin
      // level requests, one line each, enable gated
      // faults share the receive enable, no transfer start
      rx_fault_irq <= rx_irq_en && err_any;
      // receive full request doubles as transfer-unit start
      rx_full_irq <= rx_irq_en && rx_full_flag;
      // empty request doubles as transfer-unit start
      tx_empty_irq <= tx_empty_irq_en && tx_empty_flag;
      tx_done_irq <= tx_done_irq_en && tx_done_flag;
      irq_any <= (rx_irq_en && (err_any || rx_full_flag)) || (tx_empty_irq_en && tx_empty_flag)
                 || (tx_done_irq_en && tx_done_flag);
      // fault over full over empty over done
      if (rx_irq_en && err_any) irq_top <= SPIAS_PRI_FAULT;
      else if (rx_irq_en && rx_full_flag) irq_top <= SPIAS_PRI_RXF;
      else if (tx_empty_irq_en && tx_empty_flag) irq_top <= SPIAS_PRI_TXE;
      else irq_top <= SPIAS_PRI_TXD;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_unit_write;
    ce && dma_tx_wr && !tx_load && transmit_enable;
  endsequence
  sequence s_overrun_frame;
    ce && rx_done && rx_full_flag;
  endsequence
  unit_wr_clr_a: assert property (s_unit_write |=> !tx_empty_flag)
    else $error("unit write did not clear empty flag");
  unit_rd_clr_a: assert property (ce && dma_rx_rd && !rx_done |=> !rx_full_flag)
    else $error("unit read did not clear full flag");
  overrun_keep_a: assert property (s_overrun_frame |=>
    overrun_flag && rx_full_flag && $stable(dma_rx_data))
    else $error("overrun handling wrong");
  load_sets_a: assert property (ce && tx_load |=> tx_empty_flag && tx_st_r != TX_IDLE)
    else $error("load did not set empty flag");
  te_init_a: assert property (ce && !transmit_enable ##1 ce && !transmit_enable |=>
    tx_empty_flag && tx_done_flag)
    else $error("transmitter not initialised");
  sync_hold_a: assert property (sync_mode && err_any |-> !tx_load)
    else $error("sync transmit began with error flag set");
  prio_code_a: assert property (ce && rx_irq_en && err_any |=>
    irq_top == SPIAS_PRI_FAULT && irq_any)
    else $error("fault not ranked first");
  fault_gate_a: assert property (ce && !rx_irq_en |=> !rx_fault_irq)
    else $error("fault request without receive enable");
  late_off_a: assert property (ce && copy_pend_r && !rcv_enable |=>
    !copy_pend_r && $stable(dma_rx_data))
    else $error("late disable still copied");
  smp_point_a: assert property (ce && !sync_mode && rx_st_r == RX_START && rx_smp |->
    rx_cnt_r == SPIAS_OVS_SMP)
    else $error("sample not on eighth base clock");
endmodule // spias_top
`default_nettype wire

// [testbench/spias_peer.sv]
// remote serial device driving the receive line with async frames
`timescale 1ns/10ps
`default_nettype none
module spias_peer (
  output logic line,
  output logic sck,
  input wire logic tx
);
  initial line = 1'b1;
  initial sck = 1'b1;
  // one bit is 16 base ticks of one cycle each
  task automatic send(input logic [7:0] b, input logic stp);
    line <= 1'b0;
    #160;
    for (int i = 0; i < 8; i++)
    begin
      line <= b[i];
      #160;
    end
    line <= stp;
    #160;
    line <= 1'b1;
    #160;
  endtask
  task automatic brk(input logic lvl);
    line <= lvl;
  endtask
  // sync frame on an 80 ns clock: data moves on fall, taken on rise
  task automatic sx(input logic [7:0] b, output logic [7:0] r);
    for (int i = 0; i < 8; i++)
    begin
      sck <= 1'b0;
      line <= b[i];
      #40;
      sck <= 1'b1;
      r[i] = tx;
      #40;
    end
  endtask
endmodule // spias_peer
`default_nettype wire

// [testbench/spias_top_tb.sv]
// self-checking bench for the serial port request and error block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", nm, e, s); end end
module spias_top_tb;
  import spias_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bvr = 0, arv = 0, rr = 0, dwr = 0, drd = 0;
  logic [7:0] awa = 0, ara = 0, dtx = 0, b1, r1;
  logic [31:0] wd = 0, rd, sd = 32'h8d79;
  logic [1:0] rs;
  wire logic awr, wrd, bv, arr, rv, txd, rxd, iany, sck, sko, oen;
  wire logic [1:0] bresp, rresp, top;
  wire logic [31:0] rdata;
  wire logic [7:0] rxb;
  wire logic [3:0] irq;
  int num_errors = 0, checked = 0, n;
  always #5 aclk = ~aclk;
  spias_peer peer (.line(rxd), .sck(sck), .tx(txd));
  spias_top uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bvr), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .rxd_in(rxd), .txd_out(txd), .sck_in(sck), .sck_out(sko), .sck_oe_n(oen), .dma_tx_wr(dwr),
    .dma_tx_data(dtx), .dma_rx_rd(drd), .dma_rx_data(rxb), .rx_fault_irq(irq[0]),
    .rx_full_irq(irq[1]), .tx_empty_irq(irq[2]), .tx_done_irq(irq[3]), .irq_any(iany),
    .irq_top(top));
  function logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function logic [31:0] flg(input logic te, rf, ov, fe);
    return {26'h0, te, 1'b0, fe, ov, rf, te};
  endfunction
  task complete_run;
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task tmo;
    if (n >= 3000)
    begin
      num_errors++;
      complete_run;
    end
  endtask
  task wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bvr <= 1; n = 0;
    do
    begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
      n++;
    end while (!bv && n < 3000);
    bvr <= 0; rs = bresp;
    tmo;
  endtask
  task rdd(input logic [7:0] a);
    @(posedge aclk);
    ara <= a; arv <= 1; rr <= 1; n = 0;
    do
    begin
      @(posedge aclk);
      if (arr) arv <= 0;
      n++;
    end while (!rv && n < 3000);
    rr <= 0; rd = rdata; rs = rresp;
    tmo;
  endtask
  task wfor(input int k);
    n = 0;
    while (irq[k] !== 1'b1 && n < 3000)
    begin
      @(posedge aclk);
      n++;
    end
    tmo;
  endtask
  task pulse(input logic t);
    @(posedge aclk);
    if (t) dwr <= 1; else drd <= 1;
    @(posedge aclk);
    dwr <= 0; drd <= 0;
    repeat (3) @(posedge aclk);
  endtask
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    rdd(SPIAS_OFF_FLAGS);
    `CHK("flags", flg(1, 0, 0, 0), rd)
    rdd(8'h14);
    `CHK("rresp", SPIAS_RESP_ERR, rs)
    wrr(SPIAS_OFF_CTRL, 32'h1f);
    `CHK("bresp", SPIAS_RESP_OK, rs)
    repeat (2) @(posedge aclk);
    `CHK("irq", 4'hc, irq)
    `CHK("any", 1'b1, iany)
    `CHK("top", SPIAS_PRI_TXE, top)
    wfor(2);
    sd = xs(sd); dtx <= sd[7:0]; pulse(1);
    `CHK("done", 1'b0, irq[3])
    wfor(3);
    pulse(1);
    wrr(SPIAS_OFF_CTRL, 32'h17);
    repeat (2) @(posedge aclk);
    `CHK("txd", 1'b1, txd)
    `CHK("done", 1'b1, irq[3])
    repeat (2)
    begin
      sd = xs(sd); b1 = sd[7:0]; peer.send(b1, 1); wfor(1);
      `CHK("rxb", b1, rxb)
      `CHK("top", SPIAS_PRI_RXF, top)
      pulse(0);
      `CHK("full", 1'b0, irq[1])
    end
    sd = xs(sd); b1 = sd[7:0]; peer.send(b1, 1); peer.send(~b1, 1); wfor(0);
    `CHK("rxb", b1, rxb)
    `CHK("top", SPIAS_PRI_FAULT, top)
    rdd(SPIAS_OFF_FLAGS);
    `CHK("flags", flg(1, 1, 1, 0), rd)
    wrr(SPIAS_OFF_CTRL, 32'h15);
    repeat (2) @(posedge aclk);
    `CHK("rxirq", 2'h0, irq[1:0])
    pulse(0); wrr(SPIAS_OFF_FLAGS, 32'hfb); wrr(SPIAS_OFF_CTRL, 32'h17);
    sd = xs(sd); b1 = sd[7:0]; peer.send(b1, 0); wfor(0);
    `CHK("rxb", b1, rxb)
    `CHK("full", 1'b0, irq[1])
    peer.brk(0); wrr(SPIAS_OFF_FLAGS, 32'hf7);
    repeat (2) @(posedge aclk);
    wfor(0);
    rdd(SPIAS_OFF_FLAGS);
    `CHK("frm", 1'b1, rd[SPIAS_F_FRM])
    peer.brk(1);
    wrr(SPIAS_OFF_CTRL, 32'h07);
    wrr(SPIAS_OFF_FLAGS, 32'h23);
    wrr(SPIAS_OFF_CTRL, 32'h7f);
    sd = xs(sd); dtx <= sd[7:0]; pulse(1);
    repeat (2) @(posedge aclk);
    sd = xs(sd); b1 = sd[7:0]; peer.sx(b1, r1);
    `CHK("txs", dtx, r1)
    wfor(1); repeat (4) @(posedge aclk);
    `CHK("rxs", b1, rxb)
    `CHK("sck", 2'h3, {sko, oen})
    complete_run;
  end
endmodule // spias_top_tb
`default_nettype wire
